// File: bench/pb_host_model.sv
// Push-button model standing on the far side of the control block
`timescale 1ns/1ps
module pb_host_model (
    input wire logic clock,
    output logic pushbuttonInput_n
);
    // ==========================================
    // Button contact
    // Pull-up on the pin, so a released button reads high
    initial pushbuttonInput_n = 1'b1;

    // Held low for a whole number of cycles, then released
    task automatic press(input int cycles);
        @(posedge clock);
        #1 pushbuttonInput_n = 1'b0;
        repeat (cycles) @(posedge clock);
        #1 pushbuttonInput_n = 1'b1;
    endtask
endmodule

// File: bench/pushbutton_and_aux_output_ctrl_test.sv
// Self-checking bench for the push-button and auxiliary output registers
`timescale 1ns/1ps
module pushbutton_and_aux_output_ctrl_test;
    import pb_aux_pkg::*;
    logic clock = 0, sys_rst = 1, regWrite = 0, regRead = 0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rdv, d;
    logic pushbuttonInput_n, auxSwitchPin = 0, vinValid = 0, powerGoodIn = 0;
    logic auxOutputOn, auxPassThrough, statusPinOut, pbResetPulse, shipModeReq, hiZModeReq;
    logic [4:0] auxLevelApplied, code, oldCode;
    int err_total = 0, compares = 0, rstCnt = 0, shipCnt = 0, hizCnt = 0;
    int seed = 32'h30b4283a;
    // Cycles per press-time step, small so the longest hold stays short
    localparam int unsigned STEP = 4;

    // ==========================================
    // Design and partner
    pb_aux_ctrl #(.CYCLES_PER_STEP(STEP)) u_pb_aux_ctrl (
        .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
        .pushbuttonInput_n(pushbuttonInput_n), .auxSwitchPin(auxSwitchPin), .vinValid(vinValid),
        .powerGoodIn(powerGoodIn), .auxOutputOn(auxOutputOn), .auxLevelApplied(auxLevelApplied),
        .auxPassThrough(auxPassThrough), .statusPinOut(statusPinOut), .pbResetPulse(pbResetPulse),
        .shipModeReq(shipModeReq), .hiZModeReq(hiZModeReq));
    pb_host_model u_pb_host_model (.clock(clock), .pushbuttonInput_n(pushbuttonInput_n));

    initial begin
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        if (sys_rst === 1'b0) begin
            rstCnt += (pbResetPulse === 1'b1);
            shipCnt += (shipModeReq === 1'b1);
            hizCnt += (hiZModeReq === 1'b1);
        end
    end

    // ==========================================
    // Expectations
    function automatic int msCycles(input int unsigned ms);
        return int'(ms / STEP_MS * STEP);
    endfunction
    function automatic int firstThr(input logic b);
        return msCycles(b ? FIRST_LONG_MS : FIRST_SHORT_MS);
    endfunction
    function automatic int secondThr(input logic b);
        return msCycles(b ? SECOND_LONG_MS : SECOND_SHORT_MS);
    endfunction
    function automatic int holdThr(input int h);
        case (h)
            0: return msCycles(HOLD_0_MS);
            1: return msCycles(HOLD_1_MS);
            2: return msCycles(HOLD_2_MS);
            default: return msCycles(HOLD_3_MS);
        endcase
    endfunction
    function automatic logic passExp(input logic [4:0] c);
        return (AUX_BASE_MV + int'(c) * AUX_STEP_MV) > AUX_PASS_MV;
    endfunction

    // ==========================================
    // Register access and checking
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        #1 regAddr = a;
        regWrite = 1'b1;
        regWdata = v;
        @(posedge clock);
        #1 regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        #1 regAddr = a;
        regRead = 1'b1;
        @(posedge clock);
        #1 regRead = 1'b0;
        v = regRdata;
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (100000) @(posedge clock);
        err_total++;
        final_report;
    end

    initial begin
        repeat (16) @(posedge clock);
        #1 sys_rst = 1'b0;
        repeat (3) @(posedge clock);
        // ==========================================
        // Reset values and access kinds
        rd(AUX_CTRL_OFFSET, rdv);
        check(rdv, 8'h7c, "aux reset");
        rd(PB_CTRL_OFFSET, rdv);
        check(rdv, 8'h68, "pb reset");
        check({3'b0, auxLevelApplied}, 8'h1f, "level at reset");
        check({7'b0, auxPassThrough}, 8'h01, "pass at reset");
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wr(AUX_CTRL_OFFSET, d);
            rd(AUX_CTRL_OFFSET, rdv);
            check(rdv, d & 8'hfd, "aux rw");
            d = $random(seed);
            wr(PB_CTRL_OFFSET, d);
            wr(8'h09, ~d);
            rd(PB_CTRL_OFFSET, rdv);
            check(rdv, d & 8'hfc, "pb rw");
            rd(8'h09, rdv);
            check(rdv, 8'h00, "unmapped read");
        end
        $display("register access done");
        // ==========================================
        // Level code applied only while output is off
        for (int i = 0; i < 6; i++) begin
            // Corners at the pass-through edge and both ends, then random codes
            code = (i == 0) ? 5'd25 : (i == 1) ? 5'd26 : (i == 2) ? 5'd0 : (i == 3) ? 5'd31 : 5'($random(seed));
            wr(AUX_CTRL_OFFSET, {1'b0, code, 2'b00});
            repeat (4) @(posedge clock);
            check({3'b0, auxLevelApplied}, {3'b0, code}, "level applied");
            check({7'b0, auxPassThrough}, {7'b0, passExp(code)}, "pass-through");
        end
        oldCode = code;
        wr(AUX_CTRL_OFFSET, {1'b1, ~oldCode, 2'b00});
        repeat (4) @(posedge clock);
        check({7'b0, auxOutputOn}, 8'h01, "enable on");
        check({3'b0, auxLevelApplied}, {3'b0, oldCode}, "held while enabled");
        #1 auxSwitchPin = 1'b1;
        wr(AUX_CTRL_OFFSET, {1'b0, ~oldCode, 2'b00});
        repeat (4) @(posedge clock);
        check({7'b0, auxOutputOn}, 8'h01, "pin on");
        check({3'b0, auxLevelApplied}, {3'b0, oldCode}, "held while pin on");
        #1 auxSwitchPin = 1'b0;
        repeat (5) @(posedge clock);
        check({7'b0, auxOutputOn}, 8'h00, "output off");
        check({3'b0, auxLevelApplied}, {3'b0, ~oldCode}, "applied once off");
        $display("level control done");
        // ==========================================
        // Wake thresholds and read-to-clear flags
        for (int m = 0; m < 4; m++) begin
            d = {m[1], m[0], 6'b100000};
            wr(PB_CTRL_OFFSET, d);
            for (int k = 0; k < 3; k++) begin
                // Timing starts afresh on each press
                u_pb_host_model.press(k == 0 ? firstThr(m[1]) - 2 :
                    k == 1 ? firstThr(m[1]) + 2 : secondThr(m[0]) + 2);
                repeat (4) @(posedge clock);
                rd(PB_CTRL_OFFSET, rdv);
                check(rdv, d | {6'b0, k > 0, k > 1}, "wake flags");
                rd(PB_CTRL_OFFSET, rdv);
                check(rdv, d, "flags cleared by read");
            end
        end
        $display("wake flags done");
        // ==========================================
        // Long-press reset and state after reset
        for (int h = 0; h < 4; h++) begin
            d = {2'b00, h[0], h[1:0], 3'b000};
            wr(PB_CTRL_OFFSET, d);
            rstCnt = 0;
            shipCnt = 0;
            hizCnt = 0;
            u_pb_host_model.press(holdThr(h) - 10);
            repeat (4) @(posedge clock);
            check(8'(rstCnt), 8'h00, "short of hold");
            u_pb_host_model.press(holdThr(h) + 10);
            repeat (4) @(posedge clock);
            check(8'(rstCnt), 8'h01, "hold reset");
            check(8'(shipCnt), {7'b0, ~h[0]}, "ship request");
            check(8'(hizCnt), {7'b0, h[0]}, "hi-z request");
        end
        wr(AUX_CTRL_OFFSET, 8'h01);
        wr(PB_CTRL_OFFSET, 8'h00);
        rstCnt = 0;
        u_pb_host_model.press(holdThr(0) + 40);
        repeat (4) @(posedge clock);
        check(8'(rstCnt), 8'h00, "supply invalid");
        fork
            u_pb_host_model.press(holdThr(0) + 100);
            begin
                repeat (holdThr(0) + 40) @(posedge clock);
                #1 vinValid = 1'b1;
            end
        join
        repeat (4) @(posedge clock);
        check(8'(rstCnt), 8'h01, "supply becomes valid");
        $display("hold reset done");
        // ==========================================
        // Shared status pin
        for (int i = 0; i < 6; i++) begin
            #1 powerGoodIn = 1'($random(seed));
            repeat (4) @(posedge clock);
            check({7'b0, statusPinOut}, {7'b0, powerGoodIn}, "power-good on pin");
        end
        wr(PB_CTRL_OFFSET, 8'h04);
        fork
            u_pb_host_model.press(8);
            begin
                repeat (6) @(posedge clock);
                #1 check({7'b0, statusPinOut}, 8'h00, "button copy pressed");
            end
        join
        repeat (4) @(posedge clock);
        check({7'b0, statusPinOut}, 8'h01, "button copy released");
        $display("status pin done");
        final_report;
    end
endmodule

// File: design/pb_aux_ctrl.sv
// Push-button timing and auxiliary output control registers
`timescale 1ns/1ps
module pb_aux_ctrl
    import pb_aux_pkg::*;
#(
    parameter int unsigned CYCLES_PER_STEP = STEP_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    // Register access, one strobe per completed host byte
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // Pins
    input wire logic pushbuttonInput_n,
    input wire logic auxSwitchPin,
    input wire logic vinValid,
    input wire logic powerGoodIn,
    // Outputs
    output logic auxOutputOn,
    output logic [4:0] auxLevelApplied,
    output logic auxPassThrough,
    output logic statusPinOut,
    output logic pbResetPulse,
    output logic shipModeReq,
    output logic hiZModeReq
);

    typedef struct packed {
        logic [1:0] syncButton;
        logic [1:0] syncSw;
        logic [1:0] syncVin;
        logic [1:0] syncPowerGood;
        logic auxEnable;
        logic [4:0] auxLevelCode;
        logic resetNeedsVin;
        logic firstSel;
        logic secondSel;
        logic postSel;
        logic [1:0] holdSel;
        logic statusSel;
        logic firstFlag;
        logic secondFlag;
        logic [4:0] levelApplied;
        logic auxOn;
        logic auxPass;
        logic statusPin;
        logic pbReset;
        logic shipReq;
        logic hizReq;
        logic [7:0] rdata;
        press_state_e pbState;
    } ctrl_state_s;

    ctrl_state_s q;
    ctrl_state_s d;
    logic [COUNT_WIDTH-1:0] pressCount;
    logic pressed;

    // One step size scales every press time, so all of them shrink together
    localparam int unsigned FIRST_SHORT = (FIRST_SHORT_MS / STEP_MS) * CYCLES_PER_STEP;
    localparam int unsigned FIRST_LONG = (FIRST_LONG_MS / STEP_MS) * CYCLES_PER_STEP;
    localparam int unsigned SECOND_SHORT = (SECOND_SHORT_MS / STEP_MS) * CYCLES_PER_STEP;
    localparam int unsigned SECOND_LONG = (SECOND_LONG_MS / STEP_MS) * CYCLES_PER_STEP;
    localparam int unsigned HOLD_0 = (HOLD_0_MS / STEP_MS) * CYCLES_PER_STEP;
    localparam int unsigned HOLD_1 = (HOLD_1_MS / STEP_MS) * CYCLES_PER_STEP;
    localparam int unsigned HOLD_2 = (HOLD_2_MS / STEP_MS) * CYCLES_PER_STEP;
    localparam int unsigned HOLD_3 = (HOLD_3_MS / STEP_MS) * CYCLES_PER_STEP;

    // ==========================================
    // Threshold selection
    function automatic logic [COUNT_WIDTH-1:0] firstCycles(input logic sel);
        firstCycles = sel ? COUNT_WIDTH'(FIRST_LONG) : COUNT_WIDTH'(FIRST_SHORT);
    endfunction

    function automatic logic [COUNT_WIDTH-1:0] secondCycles(input logic sel);
        secondCycles = sel ? COUNT_WIDTH'(SECOND_LONG) : COUNT_WIDTH'(SECOND_SHORT);
    endfunction

    function automatic logic [COUNT_WIDTH-1:0] holdCycles(input logic [1:0] sel);
        case (sel)
            2'b00: holdCycles = COUNT_WIDTH'(HOLD_0);
            2'b01: holdCycles = COUNT_WIDTH'(HOLD_1);
            2'b10: holdCycles = COUNT_WIDTH'(HOLD_2);
            default: holdCycles = COUNT_WIDTH'(HOLD_3);
        endcase
    endfunction

    function automatic logic [7:0] readValue(input ctrl_state_s s, input logic [7:0] addr);
        if (addr == AUX_CTRL_OFFSET) begin
            readValue = {s.auxEnable, s.auxLevelCode, 1'b0, s.resetNeedsVin};
        end else if (addr == PB_CTRL_OFFSET) begin
            readValue = {s.firstSel, s.secondSel, s.postSel, s.holdSel, s.statusSel, s.firstFlag, s.secondFlag};
        end else begin
            readValue = 8'h00;
        end
    endfunction

    // Synchronised, active-high press
    assign pressed = ~q.syncButton[1];

    press_timer #(
        .COUNT_W(COUNT_WIDTH)
    ) pressTimer (
        .clock(clock),
        .sys_rst(sys_rst),
        .active(pressed),
        .count_q(pressCount)
    );

    // ==========================================
    // Next state
    always_comb begin
        d = q;
        d.syncButton = {q.syncButton[0], pushbuttonInput_n};
        d.syncSw = {q.syncSw[0], auxSwitchPin};
        d.syncVin = {q.syncVin[0], vinValid};
        d.syncPowerGood = {q.syncPowerGood[0], powerGoodIn};
        d.pbReset = 1'b0;
        d.shipReq = 1'b0;
        d.hizReq = 1'b0;

        // Register writes; read-only and unused positions are dropped
        if (regWrite && regAddr == AUX_CTRL_OFFSET) begin
            d.auxEnable = regWdata[AUX_EN_BIT];
            d.auxLevelCode = regWdata[AUX_CODE_MSB:AUX_CODE_LSB];
            d.resetNeedsVin = regWdata[AUX_NEEDVIN_BIT];
        end
        if (regWrite && regAddr == PB_CTRL_OFFSET) begin
            d.firstSel = regWdata[PB_FIRST_BIT];
            d.secondSel = regWdata[PB_SECOND_BIT];
            d.postSel = regWdata[PB_POST_BIT];
            d.holdSel = regWdata[PB_HOLD_MSB:PB_HOLD_LSB];
            d.statusSel = regWdata[PB_STATUS_BIT];
        end

        // Read data is the value before this cycle's clear
        if (regRead) begin
            d.rdata = readValue(q, regAddr);
        end

        // Output control
        d.auxOn = q.auxEnable | q.syncSw[1];
        // Level only moves while both controls hold the output off
        if (!q.auxEnable && !q.syncSw[1]) begin
            d.levelApplied = q.auxLevelCode;
        end
        d.auxPass = q.levelApplied > AUX_PASS_CODE;

        d.statusPin = q.statusSel ? q.syncButton[1] : q.syncPowerGood[1];

        // Wake flags: a set in the same cycle as the read-clear wins
        if (regRead && regAddr == PB_CTRL_OFFSET) begin
            d.firstFlag = 1'b0;
            d.secondFlag = 1'b0;
        end
        if (pressed && pressCount == firstCycles(q.firstSel)) begin
            d.firstFlag = 1'b1;
        end
        if (pressed && pressCount == secondCycles(q.secondSel)) begin
            d.secondFlag = 1'b1;
        end

        // Long-press reset, at most one per press
        case (q.pbState)
            PB_IDLE: begin
                if (pressed) begin
                    d.pbState = PB_HELD;
                end
            end
            PB_HELD: begin
                if (!pressed) begin
                    d.pbState = PB_IDLE;
                end else if (pressCount >= holdCycles(q.holdSel) && (!q.resetNeedsVin || q.syncVin[1])) begin
                    d.pbReset = 1'b1;
                    d.shipReq = ~q.postSel;
                    d.hizReq = q.postSel;
                    d.pbState = PB_DONE;
                end
            end
            PB_DONE: begin
                if (!pressed) begin
                    d.pbState = PB_IDLE;
                end
            end
            default: begin
                d.pbState = PB_IDLE;
            end
        endcase
    end

    // ==========================================
    // State register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0;
            q.syncButton <= 2'b11;
            q.auxEnable <= AUX_CTRL_RESET[AUX_EN_BIT];
            q.auxLevelCode <= AUX_CTRL_RESET[AUX_CODE_MSB:AUX_CODE_LSB];
            q.levelApplied <= AUX_CTRL_RESET[AUX_CODE_MSB:AUX_CODE_LSB];
            q.resetNeedsVin <= AUX_CTRL_RESET[AUX_NEEDVIN_BIT];
            q.firstSel <= PB_CTRL_RESET[PB_FIRST_BIT];
            q.secondSel <= PB_CTRL_RESET[PB_SECOND_BIT];
            q.postSel <= PB_CTRL_RESET[PB_POST_BIT];
            q.holdSel <= PB_CTRL_RESET[PB_HOLD_MSB:PB_HOLD_LSB];
            q.statusSel <= PB_CTRL_RESET[PB_STATUS_BIT];
            q.pbState <= PB_IDLE;
        end else begin
            q <= d;
        end
    end

    assign regRdata = q.rdata;
    assign auxOutputOn = q.auxOn;
    assign auxLevelApplied = q.levelApplied;
    assign auxPassThrough = q.auxPass;
    assign statusPinOut = q.statusPin;
    assign pbResetPulse = q.pbReset;
    assign shipModeReq = q.shipReq;
    assign hiZModeReq = q.hizReq;

    // ==========================================
    // Checks
    aux_on_follow_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        1'b1 |=> auxOutputOn == ($past(q.auxEnable) | $past(q.syncSw[1]))
    ) else $error("Auxiliary output does not follow enable and pin");

    level_hold_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        (q.auxEnable || q.syncSw[1]) |=> $stable(q.levelApplied)
    ) else $error("Level changed while output enabled");

    level_apply_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        (!q.auxEnable && !q.syncSw[1]) |=> q.levelApplied == $past(q.auxLevelCode)
    ) else $error("Level code not applied while output off");

    pass_through_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        1'b1 |=> auxPassThrough == ($past(q.levelApplied) > 5'h19)
    ) else $error("Pass-through threshold wrong");

    status_pin_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        1'b1 |=> statusPinOut == ($past(q.statusSel) ? $past(q.syncButton[1]) : $past(q.syncPowerGood[1]))
    ) else $error("Status pin source wrong");

    first_flag_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        (pressed && pressCount == firstCycles(q.firstSel)) |=> q.firstFlag
    ) else $error("First wake flag not set");

    second_flag_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        (pressed && pressCount == secondCycles(q.secondSel)) |=> q.secondFlag
    ) else $error("Second wake flag not set");

    flag_clear_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        (regRead && regAddr == PB_CTRL_OFFSET && !pressed) |=> !q.firstFlag && !q.secondFlag
    ) else $error("Wake flags not cleared by read");

    reset_qualify_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        pbResetPulse |-> (!$past(q.resetNeedsVin) || $past(q.syncVin[1]))
    ) else $error("Reset without valid input supply");

    hold_time_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        pbResetPulse |-> $past(pressCount) >= holdCycles($past(q.holdSel))
    ) else $error("Reset before hold time");

    post_state_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        pbResetPulse |-> (hiZModeReq == $past(q.postSel)) && (shipModeReq != hiZModeReq)
    ) else $error("Wrong state after reset");

    count_restart_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        !pressed |=> pressCount == '0
    ) else $error("Press count not restarted");

    unused_zero_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        (regRead && regAddr == AUX_CTRL_OFFSET) |=> regRdata[1] == 1'b0
    ) else $error("Unused bit reads nonzero");

    flag_hold_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        (q.firstFlag && !(regRead && regAddr == PB_CTRL_OFFSET)) |=> q.firstFlag
    ) else $error("First wake flag lost without a read");

    level_write_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        (regWrite && regAddr == AUX_CTRL_OFFSET) |=> q.auxLevelCode == $past(regWdata[AUX_CODE_MSB:AUX_CODE_LSB])
    ) else $error("Level code write lost");

    hold_write_a: assert property (
        @(posedge clock) disable iff (sys_rst)
        (regWrite && regAddr == PB_CTRL_OFFSET) |=> q.holdSel == $past(regWdata[PB_HOLD_MSB:PB_HOLD_LSB])
    ) else $error("Hold time selection write lost");

endmodule

// File: design/pb_aux_pkg.sv
// Constants shared by the push-button and auxiliary output register block
package pb_aux_pkg;

    // ==========================================
    // Register map
    localparam logic [7:0] AUX_CTRL_OFFSET = 8'h07;
    localparam logic [7:0] PB_CTRL_OFFSET = 8'h08;
    localparam logic [7:0] AUX_CTRL_RESET = 8'h7c;
    localparam logic [7:0] PB_CTRL_RESET = 8'h68;

    // ==========================================
    // Output control fields
    localparam int AUX_EN_BIT = 7;
    localparam int AUX_CODE_MSB = 6;
    localparam int AUX_CODE_LSB = 2;
    localparam int AUX_NEEDVIN_BIT = 0;

    // ==========================================
    // Push-button control fields
    localparam int PB_FIRST_BIT = 7;
    localparam int PB_SECOND_BIT = 6;
    localparam int PB_POST_BIT = 5;
    localparam int PB_HOLD_MSB = 4;
    localparam int PB_HOLD_LSB = 3;
    localparam int PB_STATUS_BIT = 2;

    // ==========================================
    // Level code arithmetic, millivolts
    localparam int AUX_BASE_MV = 800;
    localparam int AUX_STEP_MV = 100;
    localparam int AUX_PASS_MV = 3300;
    localparam logic [4:0] AUX_PASS_CODE = 5'((AUX_PASS_MV - AUX_BASE_MV) / AUX_STEP_MV);

    // ==========================================
    // Press times
    localparam int unsigned CLOCK_HZ = 125_000_000;
    localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / 1000;
    localparam int unsigned FIRST_SHORT_MS = 50;
    localparam int unsigned FIRST_LONG_MS = 500;
    localparam int unsigned SECOND_SHORT_MS = 1000;
    localparam int unsigned SECOND_LONG_MS = 1500;
    localparam int unsigned HOLD_0_MS = 4000;
    localparam int unsigned HOLD_1_MS = 8000;
    localparam int unsigned HOLD_2_MS = 10000;
    localparam int unsigned HOLD_3_MS = 14000;
    // Every press time is a whole number of these steps
    localparam int unsigned STEP_MS = 50;
    localparam int unsigned STEP_CYCLES = STEP_MS * CYCLES_PER_MS;
    localparam int unsigned FIRST_SHORT_CYC = FIRST_SHORT_MS * CYCLES_PER_MS;
    localparam int unsigned FIRST_LONG_CYC = FIRST_LONG_MS * CYCLES_PER_MS;
    localparam int unsigned SECOND_SHORT_CYC = SECOND_SHORT_MS * CYCLES_PER_MS;
    localparam int unsigned SECOND_LONG_CYC = SECOND_LONG_MS * CYCLES_PER_MS;
    localparam int unsigned HOLD_0_CYC = HOLD_0_MS * CYCLES_PER_MS;
    localparam int unsigned HOLD_1_CYC = HOLD_1_MS * CYCLES_PER_MS;
    localparam int unsigned HOLD_2_CYC = HOLD_2_MS * CYCLES_PER_MS;
    localparam int unsigned HOLD_3_CYC = HOLD_3_MS * CYCLES_PER_MS;
    localparam int COUNT_WIDTH = 32;

    // ==========================================
    // Press sequence
    typedef enum logic [1:0] {
        PB_IDLE = 2'b00,
        PB_HELD = 2'b01,
        PB_DONE = 2'b10
    } press_state_e;

endpackage

// File: design/press_timer.sv
// Saturating press duration counter
`timescale 1ns/1ps
module press_timer #(
    parameter int COUNT_W = 32
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic active,
    output logic [COUNT_W-1:0] count_q
);

    typedef struct packed {
        logic [COUNT_W-1:0] count;
    } timer_state_s;

    timer_state_s q;
    timer_state_s d;

    // ==========================================
    // Counting
    always_comb begin
        d = q;
        if (!active) begin
            d.count = '0;
        end else if (q.count != {COUNT_W{1'b1}}) begin
            // Saturate so a very long press never wraps and re-fires
            d.count = q.count + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count_q = q.count;

endmodule
